// ---- logic/regulator_status_params.svh ----
/*
  Offsets, field positions, reserved masks and reset values of the
  regulator status register group.
  Assumes inclusion by bare name from the status logic files.
*/
`ifndef REGULATOR_STATUS_PARAMS_SVH
`define REGULATOR_STATUS_PARAMS_SVH

// ==========================================================================
// register offsets on the serial control port
`define TOP_STATUS_ADDR        8'h1d
`define SWITCHER_STATUS_ADDR   8'h1e
`define LINEAR_STATUS_ADDR     8'h1f

// ==========================================================================
// top status field positions
`define TOP_POWER_GOOD_BIT     7
`define TOP_SYNC_INVALID_BIT   4
`define TOP_THERMAL_SD_BIT     3
`define TOP_THERMAL_WARN_BIT   2
`define TOP_OVERVOLTAGE_BIT    1

// ==========================================================================
// switcher and linear status field positions (same layout for both)
`define CH1_ENABLED_BIT        7
`define CH1_VOLT_INVALID_BIT   6
`define CH1_CURR_LIMIT_BIT     4
`define CH0_ENABLED_BIT        3
`define CH0_VOLT_INVALID_BIT   2
`define CH0_CURR_LIMIT_BIT     0

// ==========================================================================
// reserved bit masks (a one marks a reserved position) and reset values
`define TOP_STATUS_RSVD_MASK   8'h61
`define CHAN_STATUS_RSVD_MASK  8'h22
`define STATUS_RESET_VALUE     8'h00
`define READ_DATA_RESET_VALUE  8'h00

`endif

// ---- logic/regulator_status_pkg.sv ----
/*
  Types shared by the regulator status register group.
  Assumes an 8-bit register width, written into the types directly.
*/
package regulator_status_pkg;

  // ========================================================================
  // state of one status word sampler
  typedef struct packed {
    logic [7:0] word;
  } sampler_state_type;

  // ========================================================================
  // state of the register read port
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
  } port_state_type;

endpackage

// ---- logic/regulator_status_registers.sv ----
/*
  Read-only live status register group of the regulator device: top status,
  switcher status and linear regulator status, read over the internal side
  of the serial control port.
  Assumes the serial port engine issues one-cycle read/write strobes with a
  stable address, and all monitor levels are synchronous to sys_clk.
*/
// Overview of operation
// - top bit 7 shows power good pin
// - top bit 4 flags invalid sync clock
// - top bit 3 flags thermal shutdown
// - top bit 2 flags thermal warning
// - top bit 1 flags input overvoltage
// - switcher bit 7 converter 1 enabled
// - switcher bit 6 converter 1 voltage invalid
// - switcher bit 4 converter 1 current limiting
// - switcher bit 3 converter 0 enabled
// - switcher bit 2 converter 0 voltage invalid
// - switcher bit 0 converter 0 current limiting
// - linear bits 7/3 regulator enabled
// - linear bits 6/2 regulator voltage invalid
// - linear bits 4/0 regulator current limiting
`include "regulator_status_params.svh"

module regulator_status_registers (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // top level monitors
  input  wire logic       power_good_pin_state,
  input  wire logic       ext_sync_clock_invalid,
  input  wire logic       thermal_shutdown_state,
  input  wire logic       thermal_warning_state,
  input  wire logic       input_overvoltage_state,
  // switching converters
  input  wire logic       converter1_enabled,
  input  wire logic       converter1_voltage_invalid,
  input  wire logic       converter1_current_limited,
  input  wire logic       converter0_enabled,
  input  wire logic       converter0_voltage_invalid,
  input  wire logic       converter0_current_limited,
  // linear regulators
  input  wire logic       linear_reg1_enabled,
  input  wire logic       linear_reg1_voltage_invalid,
  input  wire logic       linear_reg1_current_limited,
  input  wire logic       linear_reg0_enabled,
  input  wire logic       linear_reg0_voltage_invalid,
  input  wire logic       linear_reg0_current_limited
);

  // ========================================================================
  // raw word assembly
  logic [7:0] top_raw;
  logic [7:0] switcher_raw;
  logic [7:0] linear_raw;
  logic [7:0] top_status;
  logic [7:0] switcher_status;
  logic [7:0] linear_status;

  // top status fields, reserved positions left low
  always_comb begin
    top_raw                          = 8'h00;
    top_raw[`TOP_POWER_GOOD_BIT]     = power_good_pin_state;
    top_raw[`TOP_SYNC_INVALID_BIT]   = ext_sync_clock_invalid;
    top_raw[`TOP_THERMAL_SD_BIT]     = thermal_shutdown_state;
    top_raw[`TOP_THERMAL_WARN_BIT]   = thermal_warning_state;
    top_raw[`TOP_OVERVOLTAGE_BIT]    = input_overvoltage_state;
  end

  // switcher status fields
  always_comb begin
    switcher_raw                         = 8'h00;
    switcher_raw[`CH1_ENABLED_BIT]       = converter1_enabled;
    switcher_raw[`CH1_VOLT_INVALID_BIT]  = converter1_voltage_invalid;
    switcher_raw[`CH1_CURR_LIMIT_BIT]    = converter1_current_limited;
    switcher_raw[`CH0_ENABLED_BIT]       = converter0_enabled;
    switcher_raw[`CH0_VOLT_INVALID_BIT]  = converter0_voltage_invalid;
    switcher_raw[`CH0_CURR_LIMIT_BIT]    = converter0_current_limited;
  end

  // linear status fields
  always_comb begin
    linear_raw                         = 8'h00;
    linear_raw[`CH1_ENABLED_BIT]       = linear_reg1_enabled;
    linear_raw[`CH0_ENABLED_BIT]       = linear_reg0_enabled;
    linear_raw[`CH1_VOLT_INVALID_BIT]  = linear_reg1_voltage_invalid;
    linear_raw[`CH0_VOLT_INVALID_BIT]  = linear_reg0_voltage_invalid;
    linear_raw[`CH1_CURR_LIMIT_BIT]    = linear_reg1_current_limited;
    linear_raw[`CH0_CURR_LIMIT_BIT]    = linear_reg0_current_limited;
  end

  // ========================================================================
  // live samplers, one per register
  status_word_sampler #(
    .WIDTH     (8),
    .RSVD_MASK (`TOP_STATUS_RSVD_MASK)
  ) u_top_sampler (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .raw     (top_raw),
    .word    (top_status)
  );

  status_word_sampler #(
    .WIDTH     (8),
    .RSVD_MASK (`CHAN_STATUS_RSVD_MASK)
  ) u_switcher_sampler (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .raw     (switcher_raw),
    .word    (switcher_status)
  );

  status_word_sampler #(
    .WIDTH     (8),
    .RSVD_MASK (`CHAN_STATUS_RSVD_MASK)
  ) u_linear_sampler (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .raw     (linear_raw),
    .word    (linear_status)
  );

  // ========================================================================
  // read port
  // a read taken at one edge answers at the next; the answer shows the
  // monitors as sampled one edge before the read, so a level must stand
  // two cycles before a read is sure to see it
  regulator_status_pkg::port_state_type state_ff;
  regulator_status_pkg::port_state_type nxt_state;
  logic                                 wr_seen;

  // writes land nowhere: every register here is read-only
  assign wr_seen = reg_wr & (|reg_wdata | 1'b1);

  // address decode; unmapped reads answer zero, writes never alter state
  always_comb begin
    nxt_state        = state_ff;
    nxt_state.rvalid = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        `TOP_STATUS_ADDR:      nxt_state.rdata = top_status;
        `SWITCHER_STATUS_ADDR: nxt_state.rdata = switcher_status;
        `LINEAR_STATUS_ADDR:   nxt_state.rdata = linear_status;
        default:               nxt_state.rdata = 8'h00;
      endcase
    end else if (wr_seen) begin
      nxt_state.rdata = state_ff.rdata;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff.rdata  <= `READ_DATA_RESET_VALUE;
      state_ff.rvalid <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata  = state_ff.rdata;
  assign reg_rvalid = state_ff.rvalid;

  // ========================================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence rd_top_s;
    reg_rd && reg_addr == `TOP_STATUS_ADDR;
  endsequence

  sequence rd_sw_s;
    reg_rd && reg_addr == `SWITCHER_STATUS_ADDR;
  endsequence

  sequence rd_lin_s;
    reg_rd && reg_addr == `LINEAR_STATUS_ADDR;
  endsequence

  // condition held for three cycles before a read must appear in the answer
  AST_POWER_GOOD: assert property (
    power_good_pin_state [*3] ##0 rd_top_s |=> reg_rvalid && reg_rdata[7])
    else $error("power good not reported in top status bit 7");

  AST_SYNC_INVALID: assert property (
    rd_top_s |=> reg_rdata[4] == $past(ext_sync_clock_invalid, 2))
    else $error("sync clock invalid bit mismatch");

  AST_THERMAL_SD: assert property (
    rd_top_s |=> reg_rdata[3] == $past(thermal_shutdown_state, 2))
    else $error("thermal shutdown bit mismatch");

  AST_THERMAL_WARN: assert property (
    rd_top_s |=> reg_rdata[2] == $past(thermal_warning_state, 2))
    else $error("thermal warning bit mismatch");

  AST_OVERVOLTAGE: assert property (
    rd_top_s |=> reg_rdata[1] == $past(input_overvoltage_state, 2))
    else $error("overvoltage bit mismatch");

  AST_CONV1_ENABLED: assert property (
    rd_sw_s |=> reg_rdata[7] == $past(converter1_enabled, 2))
    else $error("converter 1 enabled bit mismatch");

  AST_CONV1_VOLT: assert property (
    rd_sw_s |=> reg_rdata[6] == $past(converter1_voltage_invalid, 2))
    else $error("converter 1 voltage bit mismatch");

  AST_CONV1_LIMIT: assert property (
    rd_sw_s |=> reg_rdata[4] == $past(converter1_current_limited, 2))
    else $error("converter 1 current limit bit mismatch");

  AST_CONV0_ENABLED: assert property (
    rd_sw_s |=> reg_rdata[3] == $past(converter0_enabled, 2))
    else $error("converter 0 enabled bit mismatch");

  AST_CONV0_VOLT: assert property (
    rd_sw_s |=> reg_rdata[2] == $past(converter0_voltage_invalid, 2))
    else $error("converter 0 voltage bit mismatch");

  AST_CONV0_LIMIT: assert property (
    rd_sw_s |=> reg_rdata[0] == $past(converter0_current_limited, 2))
    else $error("converter 0 current limit bit mismatch");

  AST_LINEAR_ENABLED: assert property (
    rd_lin_s |=> reg_rdata[7] == $past(linear_reg1_enabled, 2)
             && reg_rdata[3] == $past(linear_reg0_enabled, 2))
    else $error("linear regulator enabled bits mismatch");

  AST_LINEAR_VOLT: assert property (
    rd_lin_s |=> reg_rdata[6] == $past(linear_reg1_voltage_invalid, 2)
             && reg_rdata[2] == $past(linear_reg0_voltage_invalid, 2))
    else $error("linear regulator voltage bits mismatch");

  AST_LINEAR_LIMIT: assert property (
    rd_lin_s |=> reg_rdata[4] == $past(linear_reg1_current_limited, 2)
             && reg_rdata[0] == $past(linear_reg0_current_limited, 2))
    else $error("linear regulator current limit bits mismatch");

  AST_RESERVED_ZERO: assert property (
    (rd_top_s |=> (reg_rdata & `TOP_STATUS_RSVD_MASK) == 8'h00) and
    ((rd_sw_s or rd_lin_s) |=> (reg_rdata & `CHAN_STATUS_RSVD_MASK) == 8'h00))
    else $error("reserved status bit read as one");

  AST_WRITE_IGNORED: assert property (
    reg_wr && !reg_rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("write disturbed the read port");

  // a condition that drops must drop from the next read: nothing latches
  sequence sd_dropped_s;
    $fell(thermal_shutdown_state) ##1 !thermal_shutdown_state;
  endsequence

  AST_NO_LATCH: assert property (
    sd_dropped_s ##0 rd_top_s |=> !reg_rdata[3])
    else $error("thermal shutdown bit stayed latched");

  AST_UNMAPPED_ZERO: assert property (
    reg_rd && !(reg_addr inside {`TOP_STATUS_ADDR, `SWITCHER_STATUS_ADDR,
                                 `LINEAR_STATUS_ADDR})
      |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("unmapped read did not return zero");

  // ========================================================================
  // power good level and read port timing: one answer per read cycle, nothing between reads
  // power good reported both ways, not only when the pin is active
  AST_POWER_GOOD_LEVEL: assert property (
    rd_top_s |=> reg_rdata[7] == $past(power_good_pin_state, 2))
    else $error("power good bit does not follow the pin");

  // every read cycle gets its answer strobe
  AST_READ_ANSWERED: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read got no answer strobe");

  // no strobe appears unless a read was taken
  AST_NO_SPARE_ANSWER: assert property (
    !reg_rd |=> !reg_rvalid)
    else $error("answer strobe without a read");

  // the last answer stays put until the next read
  AST_DATA_HOLDS: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  // a write in the same cycle never blocks the read
  AST_READ_BEATS_WRITE: assert property (
    reg_rd && reg_wr |=> reg_rvalid)
    else $error("read lost against a simultaneous write");

endmodule

// ---- logic/status_word_sampler.sv ----
/*
  One 8-bit live status word: each raw condition is registered every cycle,
  reserved positions are forced to zero.
  Assumes raw conditions are synchronous to sys_clk.
*/
`include "regulator_status_params.svh"

module status_word_sampler #(
  parameter int         WIDTH     = 8,
  parameter logic [7:0] RSVD_MASK = 8'h00
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] word
);

  regulator_status_pkg::sampler_state_type state_ff;
  regulator_status_pkg::sampler_state_type nxt_state;

  // ========================================================================
  // per-bit sampling, no latching
  always_comb begin
    nxt_state = state_ff;
    for (int i = 0; i < WIDTH; i++) begin
      nxt_state.word[i] = RSVD_MASK[i] ? 1'b0 : raw[i];
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff.word <= `STATUS_RESET_VALUE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign word = state_ff.word;

  // reserved positions never show a one, whatever the raw level
  AST_SAMPLER_RSVD_LOW: assert property (
    @(posedge sys_clk) disable iff (!resetn) (word & RSVD_MASK[WIDTH-1:0]) == '0)
    else $error("sampler word shows a reserved bit");

endmodule

// ---- tb/regulator_status_registers_tb.sv ----
/*
  Self-checking bench of the regulator status register group: drives the
  monitor levels and the register port, compares every read with a model.
  Assumes the design files under logic/ are compiled before this file.
*/
module regulator_status_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ========================================================================
  // signals
  logic        sys_clk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic        reg_rd;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [16:0] mon;
  logic [7:0]  last;
  int          fails;
  int          check_count;
  int          i;

  // monitor vector: top bits 4:0, converters 10:5, linear regulators 16:11
  regulator_status_registers i_regulator_status_registers (
    .sys_clk                     (sys_clk),
    .resetn                      (resetn),
    .reg_addr                    (reg_addr),
    .reg_rd                      (reg_rd),
    .reg_wr                      (reg_wr),
    .reg_wdata                   (reg_wdata),
    .reg_rdata                   (reg_rdata),
    .reg_rvalid                  (reg_rvalid),
    .power_good_pin_state        (mon[0]),
    .ext_sync_clock_invalid      (mon[1]),
    .thermal_shutdown_state      (mon[2]),
    .thermal_warning_state       (mon[3]),
    .input_overvoltage_state     (mon[4]),
    .converter1_enabled          (mon[5]),
    .converter1_voltage_invalid  (mon[6]),
    .converter1_current_limited  (mon[7]),
    .converter0_enabled          (mon[8]),
    .converter0_voltage_invalid  (mon[9]),
    .converter0_current_limited  (mon[10]),
    .linear_reg1_enabled         (mon[11]),
    .linear_reg1_voltage_invalid (mon[12]),
    .linear_reg1_current_limited (mon[13]),
    .linear_reg0_enabled         (mon[14]),
    .linear_reg0_voltage_invalid (mon[15]),
    .linear_reg0_current_limited (mon[16])
  );

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ========================================================================
  // reference model
  // channel word: ch1 enabled, invalid, limit at 7,6,4; ch0 at 3,2,0
  function automatic logic [7:0] chan_word(input logic [5:0] c);
    int w;
    w = 128 * c[0] + 64 * c[1] + 16 * c[2] + 8 * c[3] + 4 * c[4] + c[5];
    return 8'(w);
  endfunction

  // expected read value; unmapped and reserved positions give zero
  function automatic logic [7:0] model(input logic [7:0] a, input logic [16:0] m);
    int w;
    w = 0;
    case (a)
      8'h1d: w = 128 * m[0] + 16 * m[1] + 8 * m[2] + 4 * m[3] + 2 * m[4];
      8'h1e: w = chan_word(m[10:5]);
      8'h1f: w = chan_word(m[16:11]);
      default: w = 0;
    endcase
    return 8'(w);
  endfunction

  // ========================================================================
  // compare and report
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // port drivers
  // change monitors, then let sampling and read stages settle
  task automatic set_mon(input logic [16:0] v);
    @(posedge sys_clk);
    mon <= v;
    repeat (2) @(posedge sys_clk);
  endtask

  // one read, optionally with a write in the same cycle
  task automatic do_read(input logic [7:0] a, input logic wr_too);
    logic [7:0] exp;
    exp = model(a, mon);
    @(posedge sys_clk);
    reg_rd    <= 1'b1;
    reg_wr    <= wr_too;
    reg_addr  <= a;
    reg_wdata <= 8'($urandom);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    check_bit("read strobe", 1'b1, reg_rvalid);
    check_byte("read data", exp, reg_rdata);
    @(posedge sys_clk);
    #1;
    check_bit("strobe after read", 1'b0, reg_rvalid);
    check_byte("data hold", exp, reg_rdata);
    last = exp;
  endtask

  // write that must leave no trace
  task automatic do_write(input logic [7:0] a);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= 8'($urandom);
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) begin
      #1;
      check_bit("write strobe", 1'b0, reg_rvalid);
      check_byte("data after write", last, reg_rdata);
      @(posedge sys_clk);
    end
  endtask

  // ========================================================================
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    $display("wrong value run length expected finish seen hang");
    summarize();
  end

  // main sequence
  initial begin
    resetn    = 1'b0;
    reg_addr  = 8'h00;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    mon       = 17'h1ffff;
    last      = 8'h00;
    fails     = 0;
    check_count = 0;
    void'($urandom(39701));
    @(posedge sys_clk);
    #1;
    check_byte("reset data", 8'h00, reg_rdata);
    check_bit("reset strobe", 1'b0, reg_rvalid);
    @(posedge sys_clk);
    resetn <= 1'b1;
    // walking one through every monitor, all three registers read
    for (i = 0; i < 17; i++) begin
      set_mon(17'h1 << i);
      do_read(8'h1d, 1'b0);
      do_read(8'h1e, 1'b0);
      do_read(8'h1f, 1'b0);
    end
    // all set keeps reserved zero, all clear shows nothing was latched
    set_mon(17'h1ffff);
    for (i = 0; i < 3; i++) do_read(8'h1d + 8'(i), 1'b0);
    // thermal shutdown drops, top read taken the very next cycle
    @(posedge sys_clk);
    mon <= 17'h1fffb;
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= 8'h1d;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check_bit("fresh strobe", 1'b1, reg_rvalid);
    check_byte("fresh top data", model(8'h1d, 17'h1fffb), reg_rdata);
    set_mon(17'h00000);
    for (i = 0; i < 3; i++) do_read(8'h1d + 8'(i), 1'b0);
    // unmapped neighbours and extremes
    do_read(8'h00, 1'b0);
    do_read(8'h1c, 1'b0);
    do_read(8'h20, 1'b0);
    do_read(8'hff, 1'b0);
    // writes are dropped, read wins when both strobes come together
    set_mon(17'(($urandom)));
    for (i = 0; i < 3; i++) begin
      do_write(8'h1d + 8'(i));
      do_read(8'h1d + 8'(i), 1'b1);
    end
    // back-to-back reads every cycle
    set_mon(17'($urandom));
    for (i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      reg_rd   <= (i < 4);
      reg_addr <= 8'h1d + 8'(i % 3);
      #1;
      if (i > 0) begin
        check_bit("burst strobe", 1'b1, reg_rvalid);
        check_byte("burst data", model(8'h1d + 8'((i - 1) % 3), mon), reg_rdata);
      end
    end
    last = model(8'h1d, mon);
    // random monitor levels, random register
    for (i = 0; i < 40; i++) begin
      set_mon(17'($urandom));
      do_read(8'h1d + 8'($urandom_range(2)), 1'b0);
    end
    // reset in mid-run clears the read port
    set_mon(17'h1ffff);
    do_read(8'h1e, 1'b0);
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    #1;
    check_byte("mid reset data", 8'h00, reg_rdata);
    check_bit("mid reset strobe", 1'b0, reg_rvalid);
    @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    check_byte("data after release", 8'h00, reg_rdata);
    check_bit("strobe after release", 1'b0, reg_rvalid);
    last = 8'h00;
    set_mon(17'h1ffff);
    do_read(8'h1f, 1'b0);
    summarize();
  end
endmodule
